/* File: icgt_tuning.sv */
module icgt_tuning #(
  parameter int DIV_W = 4,
  parameter int STG_W = 8
) (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RESET_N,
  // register port
  input  wire icgt_pkg::icgt_bus_s  BUS,
  output logic [31:0]               RDATA,
  // power modes
  input  wire logic                 STOP_MODE,
  input  wire logic                 WAIT_MODE,
  // loop filter and monitor
  input  wire logic [3:0]           LF_DIV,
  input  wire logic [7:0]           LF_STG,
  input  wire logic                 MON_INACTIVE,
  // clock enables, analog controls, nominal bus frequency and monitor interrupt
  output logic                      OSC_CLK_EN,
  output logic                      BUS_CLK_EN,
  output logic [9:0]                CAP_UNITS,
  output logic [23:0]               BUS_NOM_HZ,
  output logic                      MON_EXPECT_SLOW,
  output logic                      XTAL_LOW_DRIVE,
  output logic                      MON_IRQ
);
  icgt_pkg::icgt_state_s st_reg;
  icgt_pkg::icgt_state_s st_next;

  // the datapath is sized for the documented field widths only
  if (DIV_W != 4 || STG_W != 8) begin : g_chk
    $error("icgt_tuning: only DIV_W=4 and STG_W=8 are supported");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // cycles per oscillator tick; zero stage is treated as one to keep ticking
  function automatic logic [17:0] period_of(input logic [3:0] d, input logic [7:0] s);
    logic [17:0] base;
    base = {10'h000, (s == 8'h00) ? 8'h01 : s};
    period_of = base << d;
  endfunction

  logic wr_ctrl;
  logic wr_div_ok;
  logic wr_stg_ok;
  assign wr_ctrl   = BUS.wr && hit(BUS.addr, icgt_pkg::OFF_CTRL);
  assign wr_div_ok = BUS.wr && hit(BUS.addr, icgt_pkg::OFF_DIV) && !st_reg.gen_en; // see RULE_01
  assign wr_stg_ok = BUS.wr && hit(BUS.addr, icgt_pkg::OFF_STG) && !st_reg.gen_en; // see RULE_01

  // next state: register file, control interlocks and the oscillator model
  always_comb begin
    logic want_gen;
    want_gen = st_reg.gen_en;
    st_next = st_reg;
    st_next.osc_en = 1'b0;
    st_next.bus_en = 1'b0;
    st_next.rdata  = 32'h0000_0000;
    st_next.mon_off_q = !st_reg.mon_en;

    // control register with its forcing between bits
    if (wr_ctrl) begin
      st_next.irq_en  = BUS.wdata[icgt_pkg::B_IRQ_EN];
      st_next.mon_en  = BUS.wdata[icgt_pkg::B_MON_EN];
      st_next.ext_sel = BUS.wdata[icgt_pkg::B_EXT_SEL];
      want_gen        = BUS.wdata[icgt_pkg::B_GEN_EN];
      if (st_reg.flag_armed && !BUS.wdata[icgt_pkg::B_FLAG]) begin
        st_next.flag       = 1'b0;
        st_next.flag_armed = 1'b0;
      end
    end
    // clearing only after external select and a whole cycle of monitor off
    if (!want_gen && !(st_reg.ext_sel && st_reg.mon_off_q)) begin
      want_gen = 1'b1; // see RULE_19
    end
    st_next.gen_en = want_gen;
    // monitor event: set beats a simultaneous clear
    if (MON_INACTIVE && st_reg.mon_en) begin
      st_next.flag = 1'b1;
    end
    if (st_next.flag) begin
      st_next.mon_en = 1'b1;
    end
    if (!st_next.gen_en) begin
      st_next.mon_en  = 1'b0;
      st_next.ext_sel = 1'b1;
    end else if (st_next.mon_en) begin
      st_next.gen_en = 1'b1;
    end
    if (!st_next.mon_en) begin
      st_next.irq_en     = 1'b0;
      st_next.flag       = 1'b0;
      st_next.flag_armed = 1'b0; // a stale read must not arm a later clear
    end

    // other registers
    if (BUS.wr && hit(BUS.addr, icgt_pkg::OFF_MULT)) begin
      st_next.mult = BUS.wdata[6:0];
    end
    if (BUS.wr && hit(BUS.addr, icgt_pkg::OFF_TRIM)) begin
      st_next.trim = BUS.wdata[7:0]; // see RULE_07
    end
    if (BUS.wr && hit(BUS.addr, icgt_pkg::OFF_CFG)) begin
      st_next.slow_opt = BUS.wdata[icgt_pkg::B_SLOW];
    end
    // fields follow the loop filter while running, software while off
    if (st_reg.gen_en) begin
      st_next.div = LF_DIV; // see RULE_20
      st_next.stg = LF_STG; // see RULE_20
    end else begin
      if (wr_div_ok) begin
        st_next.div = BUS.wdata[3:0];
      end
      if (wr_stg_ok) begin
        st_next.stg = BUS.wdata[7:0];
      end
    end

    // read data, standing only the cycle after the strobe
    if (BUS.rd) begin
      case (1'b1)
        hit(BUS.addr, icgt_pkg::OFF_CTRL): begin
          st_next.rdata[icgt_pkg::B_IRQ_EN]  = st_reg.irq_en;
          st_next.rdata[icgt_pkg::B_FLAG]    = st_reg.flag;
          st_next.rdata[icgt_pkg::B_MON_EN]  = st_reg.mon_en;
          st_next.rdata[icgt_pkg::B_EXT_SEL] = st_reg.ext_sel;
          st_next.rdata[icgt_pkg::B_GEN_EN]  = st_reg.gen_en;
          if (st_reg.flag) begin
            st_next.flag_armed = 1'b1;
          end
        end
        hit(BUS.addr, icgt_pkg::OFF_MULT): st_next.rdata[6:0] = st_reg.mult;
        hit(BUS.addr, icgt_pkg::OFF_TRIM): st_next.rdata[7:0] = st_reg.trim;
        hit(BUS.addr, icgt_pkg::OFF_DIV):  st_next.rdata[3:0] = st_reg.div;
        hit(BUS.addr, icgt_pkg::OFF_STG):  st_next.rdata[7:0] = st_reg.stg;
        hit(BUS.addr, icgt_pkg::OFF_CFG):  st_next.rdata[0]   = st_reg.slow_opt;
        default:                           st_next.rdata      = 32'h0000_0000;
      endcase
    end

    // oscillator model; wait mode is ignored on purpose so it keeps running
    case (st_reg.dco)
      icgt_pkg::DCO_IDLE: begin
        if (STOP_MODE) begin
          st_next.dco = icgt_pkg::DCO_HALT;
        end else if (st_reg.gen_en) begin
          st_next.dco = icgt_pkg::DCO_RUN;
          st_next.cnt = period_of(st_reg.div, st_reg.stg); // see RULE_02
        end
      end
      icgt_pkg::DCO_RUN: begin
        if (STOP_MODE) begin
          st_next.dco = icgt_pkg::DCO_HALT; // see RULE_14
        end else if (!st_reg.gen_en) begin
          st_next.dco = icgt_pkg::DCO_IDLE;
        end else if (st_reg.cnt <= 18'h00001) begin
          st_next.cnt     = period_of(st_reg.div, st_reg.stg); // see RULE_03
          st_next.osc_en  = 1'b1; // see RULE_12
          st_next.bus_cnt = st_reg.bus_cnt + 2'h1;
          st_next.bus_en  = (st_reg.bus_cnt == icgt_pkg::BUS_WRAP); // see RULE_09
        end else begin
          st_next.cnt = st_reg.cnt - 18'h00001;
        end
      end
      icgt_pkg::DCO_HALT: begin
        // registers untouched; restart reloads from the current fields
        if (!STOP_MODE) begin
          st_next.dco = icgt_pkg::DCO_IDLE; // see RULE_15
        end
      end
      default: st_next.dco = icgt_pkg::DCO_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg            <= '0;
      st_reg.dco        <= icgt_pkg::DCO_IDLE;
      st_reg.gen_en     <= 1'b1;
      st_reg.mon_off_q  <= 1'b1;
      st_reg.mult       <= icgt_pkg::MULT_RESET;
      st_reg.trim       <= icgt_pkg::TRIM_RESET; // see RULE_07
      st_reg.div        <= icgt_pkg::DIV_RESET;
      st_reg.stg        <= icgt_pkg::STG_RESET;
      st_reg.slow_opt   <= 1'b0; // see RULE_17
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs; more capacitor units give a lower base frequency
  assign RDATA           = st_reg.rdata;
  assign OSC_CLK_EN      = st_reg.osc_en;
  assign BUS_CLK_EN      = st_reg.bus_en;
  assign CAP_UNITS       = icgt_pkg::CAP_FIXED + {2'b00, st_reg.trim}; // see RULE_08
  assign BUS_NOM_HZ      = 24'(icgt_pkg::HZ_PER_MULT * st_reg.mult); // see RULE_09
  assign MON_EXPECT_SLOW = st_reg.slow_opt; // see RULE_16
  assign XTAL_LOW_DRIVE  = st_reg.slow_opt; // see RULE_17
  assign MON_IRQ         = st_reg.irq_en && st_reg.flag; // see RULE_18

  // assertions
  a_div_write: assert property (@(posedge CLK) disable iff (!RESET_N) // see RULE_01
    wr_div_ok |=> st_reg.div == $past(BUS.wdata[3:0]))
    else $error("divider write while off was lost");
  a_div_locked: assert property (@(posedge CLK) disable iff (!RESET_N) // see RULE_20
    RESET_N && st_reg.gen_en |=> st_reg.div == $past(LF_DIV) && st_reg.stg == $past(LF_STG))
    else $error("divider or stage not following loop filter");
  a_restart_load: assert property (@(posedge CLK) disable iff (!RESET_N) // see RULE_02
    RESET_N && st_reg.dco == icgt_pkg::DCO_IDLE && st_reg.gen_en && !STOP_MODE
    |=> st_reg.cnt == period_of($past(st_reg.div), $past(st_reg.stg)))
    else $error("restart did not load written period");
  a_stop_low: assert property (@(posedge CLK) disable iff (!RESET_N) // see RULE_14
    STOP_MODE ##1 STOP_MODE |-> !OSC_CLK_EN && !BUS_CLK_EN)
    else $error("clock output active in stop");
  a_stop_keep: assert property (@(posedge CLK) disable iff (!RESET_N) // see RULE_15
    STOP_MODE && !BUS.wr |=> $stable(st_reg.trim) && $stable(st_reg.mult))
    else $error("register changed by stop");
  a_en_guard: assert property (@(posedge CLK) disable iff (!RESET_N) // see RULE_19
    $fell(st_reg.gen_en) |-> $past(st_reg.ext_sel) && $past(st_reg.mon_off_q))
    else $error("generator disabled without guard");
  a_irq_raise: assert property (@(posedge CLK) disable iff (!RESET_N) // see RULE_18
    $rose(st_reg.flag) && st_reg.irq_en |-> MON_IRQ)
    else $error("monitor interrupt missing");
  a_cap_trim: assert property (@(posedge CLK) disable iff (!RESET_N) // see RULE_07
    $changed(st_reg.trim) |-> CAP_UNITS == 10'h180 + {2'b00, st_reg.trim})
    else $error("capacitor units do not follow trim");
  a_bus_nom: assert property (@(posedge CLK) disable iff (!RESET_N) // see RULE_09
    $changed(st_reg.mult) |-> BUS_NOM_HZ == 24'(24'd76800 * st_reg.mult))
    else $error("nominal bus frequency wrong");
  a_slow_opt: assert property (@(posedge CLK) disable iff (!RESET_N) // see RULE_16
    $rose(st_reg.slow_opt) |-> MON_EXPECT_SLOW && XTAL_LOW_DRIVE)
    else $error("slow option not applied");
  a_wait_run: assert property (@(posedge CLK) disable iff (!RESET_N) // see RULE_12
    WAIT_MODE && !STOP_MODE && st_reg.dco == icgt_pkg::DCO_RUN && st_reg.gen_en
    |=> st_reg.dco == icgt_pkg::DCO_RUN)
    else $error("oscillator halted in wait");

  c_restart: cover property (@(posedge CLK) disable iff (!RESET_N)
    $rose(st_reg.gen_en));
  c_stop_exit: cover property (@(posedge CLK) disable iff (!RESET_N)
    st_reg.dco == icgt_pkg::DCO_HALT ##1 st_reg.dco == icgt_pkg::DCO_IDLE);
  c_irq: cover property (@(posedge CLK) disable iff (!RESET_N) MON_IRQ);
  c_bus_tick: cover property (@(posedge CLK) disable iff (!RESET_N) BUS_CLK_EN);
endmodule // icgt_tuning

/* File: icgt_pkg.sv */
// Operation
// RULE_01: divider and stage fields accept writes only while the generator is off
// RULE_02: re-enabling starts the period from the last written divider and stage
// RULE_03: period scales as two to the divider times stage times a constant
// RULE_04: software keeps stage and adds log2 of period ratio to divider
// RULE_05: stage above 255 means halve stage and bump divider before writing
// RULE_06: software keeps divider in 0 to 9, else writes maximum and errors
// RULE_07: trim picks switched capacitor units out of 255, default 128
// RULE_08: more trim lowers frequency, less raises it, about 0.195 percent per unit
// RULE_09: nominal bus frequency is 307.2 kHz times multiplier over four
// RULE_10: software trims by timing a long pulse and dividing error by 0.195
// RULE_11: software should keep a nonvolatile copy of the trim value
// RULE_12: generator keeps running in wait mode and its interrupt can wake
// RULE_13: software should slow clocks or turn generator off before wait
// RULE_14: stop mode halts all activity and holds both clock outputs low
// RULE_15: stop mode keeps register values and operation resumes afterwards
// RULE_16: slow option makes the monitor expect a slower external clock
// RULE_17: slow option defaults clear and selects low-frequency crystal drive
// RULE_18: monitor interrupt is raised while its enable and flag are both set
// RULE_19: generator enable clears only with external select and monitor off a cycle
// RULE_20: divider and stage writes while enabled are ignored, loop filter drives them
package icgt_pkg;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MULT = 8'h04;
  localparam logic [7:0] OFF_TRIM = 8'h08;
  localparam logic [7:0] OFF_DIV  = 8'h0C;
  localparam logic [7:0] OFF_STG  = 8'h10;
  localparam logic [7:0] OFF_CFG  = 8'h14;
  // control and config field positions
  localparam int B_IRQ_EN  = 0;
  localparam int B_FLAG    = 1;
  localparam int B_MON_EN  = 2;
  localparam int B_EXT_SEL = 3;
  localparam int B_GEN_EN  = 4;
  localparam int B_SLOW    = 0;
  // values after reset
  localparam logic [6:0]  MULT_RESET = 7'h15;
  localparam logic [7:0]  TRIM_RESET = 8'h80;
  localparam logic [3:0]  DIV_RESET  = 4'h0;
  localparam logic [7:0]  STG_RESET  = 8'h80;
  // capacitor and frequency figures
  localparam logic [9:0]  CAP_FIXED   = 10'h180;
  localparam int          BASE_HZ     = 307200;
  localparam int          BUS_DIV     = 4;
  localparam logic [23:0] HZ_PER_MULT = 24'(BASE_HZ / BUS_DIV);
  localparam logic [1:0]  BUS_WRAP    = 2'(BUS_DIV - 1);

  typedef enum logic [2:0] {
    DCO_IDLE = 3'b001,
    DCO_RUN  = 3'b010,
    DCO_HALT = 3'b100
  } icgt_dco_e;

  // software register bus
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } icgt_bus_s;

  // whole state of the block
  typedef struct packed {
    icgt_dco_e   dco;
    logic        irq_en;
    logic        flag;
    logic        flag_armed;
    logic        mon_en;
    logic        mon_off_q;
    logic        ext_sel;
    logic        gen_en;
    logic [6:0]  mult;
    logic [7:0]  trim;
    logic [3:0]  div;
    logic [7:0]  stg;
    logic        slow_opt;
    logic [17:0] cnt;
    logic [1:0]  bus_cnt;
    logic        osc_en;
    logic        bus_en;
    logic [31:0] rdata;
  } icgt_state_s;
endpackage

/* File: icgt_cpu_model.sv */
module icgt_cpu_model (
  // clock
  input  wire logic          clk,
  // register port toward the block
  output icgt_pkg::icgt_bus_s bus,
  input  wire logic [31:0]   rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // copy of the settled trim, kept as software would in nonvolatile memory
  logic [7:0] nv_trim;

  // idle bus at time zero
  initial bus = '0;

  // strobe one cycle; address and data go inverted afterwards so nothing stale looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  // read data only stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: 32'hFFFF_FFFF, wr: 1'b0, rd: 1'b0};
    @(negedge clk);
    d = rdata;
  endtask

  // software retune; factor is scaled by 128, so 8'h80 means the same stage
  task automatic retune(input logic [3:0] d1, input logic [7:0] s1, input int shift,
                        input logic [7:0] fact, output logic [3:0] d2,
                        output logic [7:0] s2, output logic err);
    int          d;
    logic [15:0] s;
    d = int'(d1) + shift;
    s = (16'(s1) * 16'(fact)) >> 7;
    if (s > 16'h00FF) begin
      s = s >> 1;
      d = d + 1;
    end
    err = (d < 0) || (d > 9);
    d2 = err ? 4'h9 : 4'(d);
    s2 = s[7:0];
  endtask

  // trim step; error in thousandths of a percent, positive means running fast
  task automatic trim_adjust(input logic [7:0] t, input int err_m, output logic [7:0] t2);
    t2 = 8'(int'(t) + err_m / 195);
    nv_trim = t2;
  endtask
endmodule // icgt_cpu_model

/* File: internal_clock_gen_tuning_test.sv */
module internal_clock_gen_tuning_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, reset_n, stop_mode, wait_mode, mon_inactive;
  logic                osc_en, bus_en, mon_slow, xtal_low, mon_irq, nerr;
  logic [3:0]          lf_div, nd;
  logic [7:0]          lf_stg, ns, nt;
  logic [9:0]          cap_units;
  logic [23:0]         nom_hz;
  logic [31:0]         rdata, v;
  icgt_pkg::icgt_bus_s bus;
  int                  fail_count, checks, n, k;

  icgt_cpu_model cpu (.clk(clk), .bus(bus), .rdata(rdata));

  icgt_tuning uut (
    .CLK(clk), .RESET_N(reset_n), .BUS(bus), .RDATA(rdata),
    .STOP_MODE(stop_mode), .WAIT_MODE(wait_mode), .LF_DIV(lf_div), .LF_STG(lf_stg),
    .MON_INACTIVE(mon_inactive), .OSC_CLK_EN(osc_en), .BUS_CLK_EN(bus_en),
    .CAP_UNITS(cap_units), .BUS_NOM_HZ(nom_hz), .MON_EXPECT_SLOW(mon_slow),
    .XTAL_LOW_DRIVE(xtal_low), .MON_IRQ(mon_irq)
  );

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // falling edges until the next oscillator tick, bounded
  task automatic wait_osc(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (osc_en !== 1'b1 && cnt < lim);
  endtask

  // whole run is well under a thousand cycles; this cuts a hang
  initial begin
    #100_000;
    fail_count++;
    test_done();
  end

  initial begin
    fail_count = 0;
    checks = 0;
    {reset_n, stop_mode, wait_mode, mon_inactive} = 4'h0;
    lf_div = 4'h4;
    lf_stg = 8'h03;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    // values after reset, unmapped read
    cpu.rd(icgt_pkg::OFF_TRIM, v);
    chk(v, 32'h0000_0080);
    chk(32'(cap_units), 32'h0000_0200);
    cpu.rd(icgt_pkg::OFF_MULT, v);
    chk(v, 32'h0000_0015);
    chk(32'(nom_hz), 32'(icgt_pkg::BASE_HZ / icgt_pkg::BUS_DIV * 32'h15));
    cpu.rd(icgt_pkg::OFF_CFG, v);
    chk(v | 32'({mon_slow, xtal_low}), 32'h0000_0000);
    cpu.rd(8'h18, v);
    chk(v, 32'h0000_0000);
    $display("test reset done");
    // generator on: tuning writes and a bare disable are refused
    cpu.wr(icgt_pkg::OFF_DIV, 32'h0000_0007);
    cpu.wr(icgt_pkg::OFF_STG, 32'h0000_0055);
    cpu.wr(icgt_pkg::OFF_CTRL, 32'h0000_0000);
    cpu.rd(icgt_pkg::OFF_DIV, v);
    chk(v, 32'h0000_0004);
    cpu.rd(icgt_pkg::OFF_STG, v);
    chk(v, 32'h0000_0003);
    cpu.rd(icgt_pkg::OFF_CTRL, v);
    chk(32'(v[4]), 32'h0000_0001);
    $display("test refused done");
    // external select, disable, preload, restart at the written point
    cpu.retune(4'h2, 8'hC0, 0, 8'hC0, nd, ns, nerr);
    chk(32'({nerr, nd, ns}), 32'h0000_0390);
    cpu.retune(4'h9, 8'h10, 1, 8'h80, nd, ns, nerr);
    chk(32'({nerr, nd, ns}), 32'h0000_1910);
    cpu.retune(4'h0, 8'h03, 2, 8'h80, nd, ns, nerr);
    chk(32'(nerr), 32'h0000_0000);
    cpu.wr(icgt_pkg::OFF_CTRL, 32'h0000_0008);
    cpu.wr(icgt_pkg::OFF_CTRL, 32'h0000_0008);
    cpu.rd(icgt_pkg::OFF_CTRL, v);
    chk(32'(v[4:3]), 32'h0000_0001);
    cpu.wr(icgt_pkg::OFF_DIV, 32'(nd));
    cpu.wr(icgt_pkg::OFF_STG, 32'(ns));
    cpu.rd(icgt_pkg::OFF_DIV, v);
    chk(v, 32'h0000_0002);
    cpu.rd(icgt_pkg::OFF_STG, v);
    chk(v, 32'h0000_0003);
    cpu.wr(icgt_pkg::OFF_CTRL, 32'h0000_0018);
    wait_osc(60, n);
    chk(32'(n >= 11 && n <= 16), 32'h0000_0001);
    wait_osc(100, n);
    chk(32'(n), 32'h0000_0030);
    n = 0;
    while (bus_en !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    k = 0;
    do begin
      @(negedge clk);
      n++;
      k += int'(osc_en === 1'b1);
    end while (bus_en !== 1'b1 && n < 500);
    chk(32'(k), 32'h0000_0004);
    $display("test restart done");
    // trim and multiplier at the outputs
    cpu.trim_adjust(8'h80, -15015, nt);
    cpu.wr(icgt_pkg::OFF_TRIM, 32'(nt));
    @(negedge clk);
    chk(32'(cap_units), 32'h0000_01B3);
    cpu.wr(icgt_pkg::OFF_MULT, 32'h0000_0002);
    @(negedge clk);
    chk(32'(nom_hz), 32'(icgt_pkg::BASE_HZ / icgt_pkg::BUS_DIV * 32'h2));
    // stop halts both clocks and keeps registers; wait keeps running
    @(posedge clk);
    stop_mode <= 1'b1;
    repeat (3) @(negedge clk);
    k = 0;
    repeat (100) begin
      @(negedge clk);
      k += int'(osc_en !== 1'b0 || bus_en !== 1'b0);
    end
    chk(32'(k), 32'h0000_0000);
    cpu.rd(icgt_pkg::OFF_TRIM, v);
    chk(v, 32'h0000_0033);
    chk(v, 32'(cpu.nv_trim));
    @(posedge clk);
    stop_mode <= 1'b0;
    wait_osc(80, n);
    chk(32'(n <= 60), 32'h0000_0001);
    cpu.wr(icgt_pkg::OFF_MULT, 32'h0000_0001);
    @(posedge clk);
    wait_mode <= 1'b1;
    wait_osc(100, n);
    wait_osc(100, n);
    chk(32'(n), 32'h0000_0030);
    @(posedge clk);
    wait_mode <= 1'b0;
    $display("test power modes done");
    // slow option both ways
    for (k = 1; k >= 0; k--) begin
      cpu.wr(icgt_pkg::OFF_CFG, 32'(k));
      @(negedge clk);
      chk(32'({mon_slow, xtal_low}), k ? 32'h0000_0003 : 32'h0000_0000);
    end
    // monitor interrupt: raise, mask, unmask, clear by read then write
    cpu.wr(icgt_pkg::OFF_CTRL, 32'h0000_001C);
    cpu.wr(icgt_pkg::OFF_CTRL, 32'h0000_001D);
    @(posedge clk);
    mon_inactive <= 1'b1;
    wait_mode <= 1'b1;
    @(posedge clk);
    mon_inactive <= 1'b0;
    @(negedge clk);
    chk(32'(mon_irq), 32'h0000_0001);
    chk(32'(mon_irq & wait_mode), 32'h0000_0001);
    cpu.wr(icgt_pkg::OFF_CTRL, 32'h0000_001C);
    @(negedge clk);
    chk(32'(mon_irq), 32'h0000_0000);
    cpu.wr(icgt_pkg::OFF_CTRL, 32'h0000_001D);
    @(negedge clk);
    chk(32'(mon_irq), 32'h0000_0001);
    cpu.rd(icgt_pkg::OFF_CTRL, v);
    chk(32'(v[1]), 32'h0000_0001);
    cpu.wr(icgt_pkg::OFF_CTRL, 32'h0000_001D);
    @(negedge clk);
    chk(32'(mon_irq), 32'h0000_0000);
    $display("test options and monitor done");
    test_done();
  end
endmodule // internal_clock_gen_tuning_test
